// >>> hdl/analog_comparator_control.sv
// Comparator control: status/control register, events, interrupt, pin
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
// Operation
// RULE_01: Logic keeps running unchanged while the processor is halted in debug.
// RULE_02: Control bit 7 set enables the comparator, cleared disables it.
// RULE_03: Control bit 6 picks the positive pin at zero, the bandgap at one.
// RULE_04: Control bit 5 is the event flag, set on a matching output edge.
// RULE_05: Writing one to the flag clears it, writing zero leaves it.
// RULE_06: Control bit 4 lets the set flag raise the interrupt request.
// RULE_07: Control bit 3 is read-only and shows the live comparator output.
// RULE_08: The output level bit resets to zero and reads zero while disabled.
// RULE_09: Control bit 2 drives the output pin, only while enabled.
// RULE_10: Bits 1:0 pick falling, rising, falling or either edge.
// RULE_11: Output is high when non-inverting input is above inverting input.
// RULE_12: The negative pin always feeds the inverting input.
// RULE_13: An event in stop sets the flag and wakes the processor.
// RULE_14: A reset out of stop returns every register to its reset value.
// RULE_15: When enabled before wait the block runs and may wake the processor.
// RULE_16: The comparator output crosses two flops before any logic uses it.
// RULE_17: A flag set in the same cycle as its clear leaves the flag set.
module analog_comparator_control (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic COMPARE_RAW_IN,
  output logic MODULE_ENABLE_OUT,
  output logic REFERENCE_SELECT_OUT,
  output logic COMPARE_OUT_PIN_OUT,
  output logic COMPARE_OUT_PIN_OE_OUT,
  output logic IRQ_OUT
);
  typedef struct packed {
    logic enable;
    logic ref_sel;
    logic flag;
    logic irq_en;
    logic pin_en;
    logic [1:0] mode;
    logic int_status;
    logic int_mask;
    logic pin_level;
    logic pin_oe;
  } ctrl_t;

  ctrl_t c_r;
  ctrl_t c_nxt;
  cmp_regbus_if bus ();
  logic level;
  logic rise;
  logic fall;
  logic evt;
  logic csr_wr;
  logic mask_wr;
  logic stat_rd;
  logic flag_clr;
  logic [7:0] csr_view;

  // Edge kinds that count as an event for a mode
  function automatic logic match_event(input logic [1:0] mode, input logic r,
                                       input logic f);
    logic hit;
    hit = 1'b0;
    // Codes 00 and 10 both mean falling, so no code is illegal
    unique case (mode)
      cmp_ctrl_pkg::MODE_FALL_A: hit = f;
      cmp_ctrl_pkg::MODE_RISE: hit = r;
      cmp_ctrl_pkg::MODE_FALL_B: hit = f;
      cmp_ctrl_pkg::MODE_EITHER: hit = r || f;
    endcase
    return hit;
  endfunction

  // Bus front end; transfer size is not checked, words only
  cmp_ahb_slave u_slave (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .hsel_in(HSEL_IN),
    .haddr_in(HADDR_IN),
    .htrans_in(HTRANS_IN),
    .hwrite_in(HWRITE_IN),
    .hwdata_in(HWDATA_IN),
    .hready_in(HREADY_IN),
    .hrdata_out(HRDATA_OUT),
    .hreadyout_out(HREADYOUT_OUT),
    .hresp_out(HRESP_OUT),
    .bus(bus)
  );

  // RULE_16 two-flop crossing
  cmp_edge_sync u_sync (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .raw_in(COMPARE_RAW_IN),
    .enable_in(c_r.enable),
    .level_out(level),
    .rise_out(rise),
    .fall_out(fall)
  );

  // Access decode
  assign csr_wr = bus.wr_en && (bus.addr == cmp_ctrl_pkg::CSR_OFFSET);
  assign mask_wr = bus.wr_en && (bus.addr == cmp_ctrl_pkg::INT_MASK_OFFSET);
  assign stat_rd = bus.rd_en && (bus.addr == cmp_ctrl_pkg::INT_STATUS_OFFSET);
  // RULE_05 write one clears
  assign flag_clr = csr_wr && bus.wdata[cmp_ctrl_pkg::BIT_FLAG];

  // RULE_10 mode picks the edge
  // RULE_11 high means positive side above
  assign evt = match_event(c_r.mode, rise, fall);

  // RULE_07 live level in bit 3
  // RULE_08 level gated by enable
  always_comb
  begin
    csr_view = cmp_ctrl_pkg::CSR_RESET;
    csr_view[cmp_ctrl_pkg::BIT_ENABLE] = c_r.enable;
    csr_view[cmp_ctrl_pkg::BIT_REF_SEL] = c_r.ref_sel;
    csr_view[cmp_ctrl_pkg::BIT_FLAG] = c_r.flag;
    csr_view[cmp_ctrl_pkg::BIT_IRQ_EN] = c_r.irq_en;
    csr_view[cmp_ctrl_pkg::BIT_LEVEL] = level;
    csr_view[cmp_ctrl_pkg::BIT_PIN_EN] = c_r.pin_en;
    csr_view[cmp_ctrl_pkg::BIT_MODE_HI:cmp_ctrl_pkg::BIT_MODE_LO] = c_r.mode;
  end

  // Read mux; unmapped words read zero
  always_comb
  begin
    bus.rdata = cmp_ctrl_pkg::RDATA_NONE;
    if (bus.addr == cmp_ctrl_pkg::CSR_OFFSET)
    begin
      bus.rdata[7:0] = csr_view;
    end
    else if (bus.addr == cmp_ctrl_pkg::INT_STATUS_OFFSET)
    begin
      bus.rdata[cmp_ctrl_pkg::BIT_EVENT] = c_r.int_status;
    end
    else if (bus.addr == cmp_ctrl_pkg::INT_MASK_OFFSET)
    begin
      bus.rdata[cmp_ctrl_pkg::BIT_EVENT] = c_r.int_mask;
    end
  end

  // Next state of the control block
  always_comb
  begin
    c_nxt = c_r;
    if (csr_wr)
    begin
      // RULE_02 enable bit
      c_nxt.enable = bus.wdata[cmp_ctrl_pkg::BIT_ENABLE];
      // RULE_03 reference choice
      c_nxt.ref_sel = bus.wdata[cmp_ctrl_pkg::BIT_REF_SEL];
      c_nxt.irq_en = bus.wdata[cmp_ctrl_pkg::BIT_IRQ_EN];
      c_nxt.pin_en = bus.wdata[cmp_ctrl_pkg::BIT_PIN_EN];
      c_nxt.mode = bus.wdata[cmp_ctrl_pkg::BIT_MODE_HI:cmp_ctrl_pkg::BIT_MODE_LO];
    end
    if (mask_wr)
    begin
      c_nxt.int_mask = bus.wdata[cmp_ctrl_pkg::BIT_EVENT];
    end
    // RULE_04 edge sets the flag
    // RULE_17 set beats clear
    c_nxt.flag = evt || (c_r.flag && !flag_clr);
    // Sticky status, cleared by reading it; set still wins
    c_nxt.int_status = evt || (c_r.int_status && !stat_rd);
    // RULE_09 pin only while enabled
    c_nxt.pin_oe = c_r.enable && c_r.pin_en;
    c_nxt.pin_level = c_r.enable && c_r.pin_en && level;
  end

  // RULE_14 reset restores all state
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      c_r <= '0;
    end
    else
    begin
      c_r <= c_nxt;
    end
  end

  // Analog core controls
  assign MODULE_ENABLE_OUT = c_r.enable;
  // RULE_12 negative pin stays on the inverting side
  assign REFERENCE_SELECT_OUT = c_r.ref_sel;
  assign COMPARE_OUT_PIN_OUT = c_r.pin_level;
  assign COMPARE_OUT_PIN_OE_OUT = c_r.pin_oe;

  // RULE_01 no halt gating at all
  // RULE_13 level request also wakes from stop
  // RULE_15 same path wakes from wait
  // RULE_06 flag with enable raises request
  assign IRQ_OUT = (c_r.flag && c_r.irq_en) || (c_r.int_status && c_r.int_mask);

  // Checks on the documented behaviour
  // Event steps: a matching edge, then flag and status one edge later
  sequence match_edge_s;
    evt;
  endsequence
  sequence flag_and_status_s;
    c_r.flag && c_r.int_status;
  endsequence
  // Pin steps: armed now, the pin flops follow one edge later
  sequence pin_armed_s;
    c_r.enable && c_r.pin_en;
  endsequence

  // RULE_04 both records set
  event_marks_both_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_04
    match_edge_s |=> flag_and_status_s)
    else $error("event did not set flag and status");

  // RULE_04 no spurious flag
  flag_only_event_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_04
    !evt && !c_r.flag |=> !c_r.flag)
    else $error("flag set without an event");

  // RULE_10 rise mode sets
  rise_mode_set_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_10
    c_r.mode == cmp_ctrl_pkg::MODE_RISE && rise |=> c_r.flag)
    else $error("rising edge missed in rise mode");

  // RULE_10 fall modes set
  fall_mode_set_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_10
    (c_r.mode == cmp_ctrl_pkg::MODE_FALL_A || c_r.mode == cmp_ctrl_pkg::MODE_FALL_B)
      && fall |=> c_r.flag)
    else $error("falling edge missed in fall mode");

  // RULE_10 fall ignores rise
  fall_mode_quiet_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_10
    (c_r.mode == cmp_ctrl_pkg::MODE_FALL_A || c_r.mode == cmp_ctrl_pkg::MODE_FALL_B)
      && rise && !c_r.flag && !csr_wr |=> !c_r.flag)
    else $error("rising edge set flag in fall mode");

  // RULE_10 mode from write
  mode_write_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_10
    csr_wr |=> c_r.mode
      == $past(bus.wdata[cmp_ctrl_pkg::BIT_MODE_HI:cmp_ctrl_pkg::BIT_MODE_LO]))
    else $error("mode not taken from write");

  // RULE_03 reference from write
  ref_write_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_03
    csr_wr |=> REFERENCE_SELECT_OUT == $past(bus.wdata[cmp_ctrl_pkg::BIT_REF_SEL]))
    else $error("reference select not taken from write");

  // RULE_06 interrupt enable written
  irq_write_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_06
    csr_wr |=> c_r.irq_en == $past(bus.wdata[cmp_ctrl_pkg::BIT_IRQ_EN]))
    else $error("interrupt enable not taken from write");

  // RULE_09 pin follows level
  pin_follow_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_09
    pin_armed_s |=> COMPARE_OUT_PIN_OE_OUT && (COMPARE_OUT_PIN_OUT == $past(level)))
    else $error("pin did not follow the level");

  // RULE_09 pin off unarmed
  pin_idle_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_09
    !c_r.pin_en ##1 !c_r.pin_en |-> !COMPARE_OUT_PIN_OE_OUT && !COMPARE_OUT_PIN_OUT)
    else $error("pin driven with its enable clear");

  // RULE_02 disabled makes no event
  disabled_no_event_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_02
    !c_r.enable |-> !evt)
    else $error("event while disabled");

  // RULE_13 event wakes processor
  wake_request_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_13
    evt && c_r.irq_en && !csr_wr |=> IRQ_OUT)
    else $error("event with interrupt enabled gave no request");

  // Sticky status holds
  status_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    c_r.int_status && !stat_rd |=> c_r.int_status)
    else $error("status lost without a read");

  // Mask taken from write
  mask_write_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    mask_wr |=> c_r.int_mask == $past(bus.wdata[cmp_ctrl_pkg::BIT_EVENT]))
    else $error("mask not taken from write");

  // RULE_04 edge sets flag
  flag_set_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_04
    evt |=> c_r.flag)
    else $error("event did not set flag");

  // RULE_05 one clears flag
  flag_clear_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_05
    flag_clr && !evt |=> !c_r.flag)
    else $error("write one did not clear flag");

  // RULE_05 zero keeps flag
  flag_hold_zero_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_05
    csr_wr && !flag_clr && c_r.flag |=> c_r.flag)
    else $error("write zero changed flag");

  // RULE_17 set beats clear
  set_over_clear_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_17
    flag_clr && evt |=> c_r.flag)
    else $error("event lost against clear");

  // RULE_06 flag raises request
  irq_from_flag_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_06
    c_r.flag && c_r.irq_en |-> IRQ_OUT)
    else $error("flag with enable gave no request");

  // RULE_08 level hidden disabled
  level_disabled_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_08
    !c_r.enable |-> !csr_view[cmp_ctrl_pkg::BIT_LEVEL])
    else $error("level bit high while disabled");

  // RULE_09 pin off disabled
  pin_gated_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_09
    !c_r.enable ##1 !c_r.enable |-> !COMPARE_OUT_PIN_OE_OUT && !COMPARE_OUT_PIN_OUT)
    else $error("pin driven while disabled");

  // RULE_10 rise ignores fall
  rise_mode_quiet_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_10
    c_r.mode == cmp_ctrl_pkg::MODE_RISE && fall && !c_r.flag && !csr_wr |=> !c_r.flag)
    else $error("falling edge set flag in rise mode");

  // RULE_10 either edge counts
  either_mode_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_10
    c_r.mode == cmp_ctrl_pkg::MODE_EITHER && (rise || fall) |=> c_r.flag)
    else $error("edge missed in either mode");

  // RULE_02 enable from write
  enable_write_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // RULE_02
    csr_wr |=> MODULE_ENABLE_OUT == $past(bus.wdata[cmp_ctrl_pkg::BIT_ENABLE]))
    else $error("enable bit not taken from write");

  // Status read clears
  status_read_clear_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    stat_rd && !evt |=> !c_r.int_status)
    else $error("status read did not clear");
endmodule

// >>> shared/cmp_ctrl_pkg.sv
// Constants shared by the comparator control block
package cmp_ctrl_pkg;
  // Register byte offsets
  localparam logic [31:0] CSR_OFFSET = 32'h0000_0000;
  localparam logic [31:0] INT_STATUS_OFFSET = 32'h0000_0004;
  localparam logic [31:0] INT_MASK_OFFSET = 32'h0000_0008;
  // Control register field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_REF_SEL = 6;
  localparam int BIT_FLAG = 5;
  localparam int BIT_IRQ_EN = 4;
  localparam int BIT_LEVEL = 3;
  localparam int BIT_PIN_EN = 2;
  localparam int BIT_MODE_HI = 1;
  localparam int BIT_MODE_LO = 0;
  localparam int BIT_EVENT = 0;
  // Reset values
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic INT_MASK_RESET = 1'h0;
  // Event mode encodings
  localparam logic [1:0] MODE_FALL_A = 2'h0;
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_FALL_B = 2'h2;
  localparam logic [1:0] MODE_EITHER = 2'h3;
  // Bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
  // Synchroniser depth in clock cycles
  localparam int SYNC_STAGES = 2;
endpackage

// >>> shared/cmp_regbus_if.sv
// Register access strobes between bus slave and register file
`timescale 1ns/1ps
interface cmp_regbus_if;
  logic wr_en;
  logic rd_en;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave (output wr_en, output rd_en, output addr, output wdata, input rdata);
  modport regs (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface

// >>> hdl/cmp_ahb_slave.sv
// AHB-Lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module cmp_ahb_slave (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  cmp_regbus_if.slave bus
);
  typedef struct packed {
    logic pend_wr;
    logic pend_rd;
    logic [31:0] addr;
    logic [31:0] rdata;
  } slave_t;
  slave_t s_r;
  slave_t s_nxt;
  logic take;

  // Address phase accepted only on a ready bus
  assign take = hsel_in && htrans_in[1] && hready_in;

  // Next state: reads hold one wait so data comes from a flop
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pend_wr = take && hwrite_in;
    s_nxt.pend_rd = take && !hwrite_in;
    if (take)
    begin
      s_nxt.addr = haddr_in;
    end
    if (s_r.pend_rd)
    begin
      s_nxt.rdata = bus.rdata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Strobes toward the register file
  assign bus.wr_en = s_r.pend_wr;
  assign bus.rd_en = s_r.pend_rd;
  assign bus.addr = s_r.addr;
  assign bus.wdata = hwdata_in;
  assign hrdata_out = s_r.rdata;
  assign hreadyout_out = !s_r.pend_rd;
  assign hresp_out = cmp_ctrl_pkg::HRESP_OKAY;

  sequence rd_taken_s;
    take && !hwrite_in;
  endsequence
  sequence rd_answer_s;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  read_wait_one_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rd_taken_s |=> rd_answer_s)
    else $error("read did not answer after one wait");
endmodule

// >>> hdl/cmp_edge_sync.sv
// Comparator output synchroniser and gated edge detector
`timescale 1ns/1ps
module cmp_edge_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic raw_in,
  input wire logic enable_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  typedef struct packed {
    logic [cmp_ctrl_pkg::SYNC_STAGES-1:0] sync;
    logic prev;
  } sync_t;
  sync_t s_r;
  sync_t s_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[0], raw_in};
    s_nxt.prev = level_out;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Disabled reads low; disabling itself makes no edge
  assign level_out = enable_in && s_r.sync[1];
  assign rise_out = enable_in && level_out && !s_r.prev;
  assign fall_out = enable_in && !level_out && s_r.prev;

  sync_delay_two_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    enable_in && $past(rst_b_in, 2) |-> level_out == $past(raw_in, 2)) // RULE_16
    else $error("synchronised level not two cycles late");
endmodule

// >>> sim/cmp_core_model.sv
// Behavioural analog comparator core with its two input pins
`timescale 1ns/1ps
module cmp_core_model #(
  // Internal reference level in millivolts
  parameter logic [15:0] BANDGAP_MV = 16'h04B0
) (
  input wire logic enable_in,
  input wire logic ref_sel_in,
  input wire logic [15:0] pos_mv_in,
  input wire logic [15:0] neg_mv_in,
  output logic raw_out
);
  logic [15:0] noninv_mv;
  // positive pin or bandgap on plus, minus pin fixed
  // high while plus is above minus; a disabled core rests low
  always_comb
  begin
    noninv_mv = ref_sel_in ? BANDGAP_MV : pos_mv_in;
    raw_out = enable_in && (noninv_mv > neg_mv_in);
  end
endmodule

// >>> sim/test_analog_comparator_control.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module test_analog_comparator_control;
  localparam logic [31:0] CSR = cmp_ctrl_pkg::CSR_OFFSET;
  localparam logic [31:0] STS = cmp_ctrl_pkg::INT_STATUS_OFFSET;
  localparam logic [31:0] MSK = cmp_ctrl_pkg::INT_MASK_OFFSET;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, raw, mod_en, ref_sel, pin, pin_oe, irq;
  logic [15:0] pos_mv = 16'h00C8;
  logic [15:0] neg_mv = 16'h01F4;
  logic [31:0] rd;
  int errors = 0;
  int checked = 0;

  // Free running bus clock
  always #5 clk = ~clk;

  analog_comparator_control analog_comparator_control_inst (
    .CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .COMPARE_RAW_IN(raw), .MODULE_ENABLE_OUT(mod_en), .REFERENCE_SELECT_OUT(ref_sel),
    .COMPARE_OUT_PIN_OUT(pin), .COMPARE_OUT_PIN_OE_OUT(pin_oe), .IRQ_OUT(irq)
  );

  cmp_core_model cmp_core_model_inst (
    .enable_in(mod_en), .ref_sel_in(ref_sel), .pos_mv_in(pos_mv),
    .neg_mv_in(neg_mv), .raw_out(raw)
  );

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk1(input string what, input logic seen, input logic exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask

  // Ready is looked at settled, then the edge that takes it is passed
  // No limit of its own: only the watchdog ends a hung wait
  task automatic ready_wait();
    @(negedge clk);
    while (hready !== 1'b1)
    begin
      @(negedge clk);
    end
    rd = hrdata;
    @(posedge clk);
  endtask

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= cmp_ctrl_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    ready_wait();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    ready_wait();
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  // Move the analog inputs, then allow the two-flop sync and event edge
  task automatic pins(input logic [15:0] p, input logic [15:0] n);
    @(posedge clk);
    pos_mv <= p;
    neg_mv <= n;
    repeat (5) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(CSR, 32'h00, "csr reset");
    rdchk(STS, 32'h00, "status reset");
    rdchk(MSK, 32'h00, "mask reset");
    chk1("okay resp", hresp, 1'b0);
    bus(1'b1, 32'h10, 32'hFF);
    rdchk(32'h10, 32'h00, "unmapped");
    bus(1'b1, CSR, 32'h95);
    rdchk(CSR, 32'h95, "csr enabled");
    chk1("enable out", mod_en, 1'b1);
    pins(16'h0384, 16'h01F4);
    rdchk(CSR, 32'hBD, "rise event");
    chk1("irq on", irq, 1'b1);
    chk1("pin level", pin, 1'b1);
    chk1("pin oe", pin_oe, 1'b1);
    bus(1'b1, CSR, 32'h95);
    rdchk(CSR, 32'hBD, "zero keeps flag");
    bus(1'b1, CSR, 32'hB5);
    rdchk(CSR, 32'h9D, "one clears flag");
    chk1("irq off", irq, 1'b0);
    // Sticky status seen through the mask, cleared by its read
    rdchk(STS, 32'h01, "status sticky");
    bus(1'b1, CSR, 32'h81);
    bus(1'b1, MSK, 32'h01);
    rdchk(MSK, 32'h01, "mask set");
    pins(16'h00C8, 16'h01F4);
    chk1("no fall event", irq, 1'b0);
    pins(16'h0384, 16'h01F4);
    chk1("irq status", irq, 1'b1);
    rdchk(STS, 32'h01, "status set");
    chk1("irq after read", irq, 1'b0);
    rdchk(STS, 32'h00, "status cleared");
    bus(1'b1, MSK, 32'h00);
    // Clear written in the very cycle the synchronised rise arrives
    pins(16'h00C8, 16'h01F4);
    @(posedge clk);
    pos_mv <= 16'h0384;
    bus(1'b1, CSR, 32'hA1);
    rdchk(CSR, 32'hA9, "set beats clear");
    // Every event mode against both edges
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, CSR, 32'hA0 | m);
      pins(16'h00C8, 16'h01F4);
      rdchk(CSR, 32'h80 | m | ((m != 1) ? 32'h20 : 32'h0), "fall mode");
      bus(1'b1, CSR, 32'hA0 | m);
      pins(16'h0384, 16'h01F4);
      rdchk(CSR, 32'h88 | m | ((m % 2 == 1) ? 32'h20 : 32'h0), "rise mode");
    end
    // Bandgap on plus, minus pin still decides
    bus(1'b1, CSR, 32'hE0);
    pins(16'h00C8, 16'h03E8);
    rdchk(CSR, 32'hC8, "bandgap above");
    chk1("ref select out", ref_sel, 1'b1);
    pins(16'h07D0, 16'h05DC);
    rdchk(CSR, 32'hE0, "minus above bandgap");
    // Disabled block hides level and pin
    bus(1'b1, CSR, 32'h24);
    pins(16'h0384, 16'h01F4);
    rdchk(CSR, 32'h04, "disabled");
    chk1("pin oe off", pin_oe, 1'b0);
    chk1("pin low", pin, 1'b0);
    // Second reset in mid-run
    bus(1'b1, CSR, 32'h95);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(CSR, 32'h00, "reset again");
    tally_and_finish();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule
